// File: src/bbc_top.sv
// Contract
// R1: Read when write strobe high, select one low, select two high.
// R2: Thirteen address bits pick one of 8192 bytes.
// R3: Drive data only when both selects and output gate active in read.
// R4: Address change mid-read holds old data briefly, then undefined until new.
// R5: Write when write strobe and select one low, select two high.
// R6: Write starts at last active edge, ends at first inactive edge.
// R7: Host keeps address stable during write and ends strobe before next cycle.
// R8: Host should keep output gate high during writes.
// R9: Write strobe falling releases driving outputs.
// R10: Select and strobe together keep outputs floating all cycle.
// R11: Power fail deselects, blocks writes, floats outputs, ignores inputs.
// R12: Interrupted write may only corrupt the addressed byte.
// R13: Writes stay blocked until supply passes upper threshold.
// R14: Running counters stay separate from bus-visible time bytes.
// R15: Read-halt bit set stops time byte updates while it stays one.
// R16: Halted time bytes keep the time current at halt.
// R17: All time bytes update together; halt waits for update end.
// R18: Clearing read-halt resumes refresh within one second.
// R19: Write-halt bit halts updates like the read-halt bit.
// R20: Clearing write-halt loads counters from time bytes, next update within second.
// R21: Host loads time bytes as BCD, 24-hour format.
// R22: Host writes zero to fixed-zero time bits.
// R23: Host should halt updates before reading time bytes.
// R24: Time bytes occupy the top eight addresses, control lowest.
// R25: Unhalted, time bytes refresh from counters once per second.
`timescale 1ns/1ps
`default_nettype none
module bbc_top
   import bbc_pkg::*;
#(
   parameter int SECOND_COUNT = SECOND_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Memory bus pins
   input wire logic [ADDR_W-1:0] byte_address,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic select_one_n,
   input wire logic select_two,
   input wire logic output_gate_n,
   input wire logic write_strobe_n,
   // Supply monitor: low below lower trip, high above upper trip
   input wire logic supply_above_low,
   input wire logic supply_above_high
);
   localparam int PIN_W = ADDR_W + DATA_W + 6;
   localparam int CNT_W = $clog2(SECOND_COUNT + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SECOND_COUNT - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   // Synchronised pins
   logic [PIN_W-1:0] pins_sync;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] din_s;
   logic sel1_n_s, sel2_s, gate_n_s, wr_n_s, pf_low_s, pf_high_s;

   bbc_sync #(.WIDTH(PIN_W)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .async_in({byte_address, data_in, select_one_n, select_two, output_gate_n,
                 write_strobe_n, supply_above_low, supply_above_high}),
      .sync_out(pins_sync)
   );
   assign {addr_s, din_s, sel1_n_s, sel2_s, gate_n_s, wr_n_s, pf_low_s, pf_high_s} = pins_sync;

   // Storage: plain RAM plus the time byte window
   logic [DATA_W-1:0] mem [DEPTH];
   logic [7:0] control_reg, control_next;
   logic [7:0] tbyte_reg [NUM_TIME];
   logic [7:0] tbyte_next [NUM_TIME];
   logic [7:0] cnt_reg [NUM_TIME];
   logic [7:0] cnt_next [NUM_TIME];
   logic [CNT_W-1:0] tick_reg, tick_next;
   logic pend_reg, pend_next;
   bbc_state_t state_reg, state_next;
   logic [ADDR_W-1:0] last_addr_reg, last_addr_next;
   logic [DATA_W-1:0] dout_reg, dout_next;
   logic oe_reg, oe_next;
   logic blocked_reg, blocked_next;
   logic wr_n_d_reg, wr_n_d_next;
   logic sel_d_reg, sel_d_next;
   logic float_reg, float_next;

   // Decode
   logic selected, read_mode, write_mode, write_start, in_clock, halt, sel_rise;
   logic [2:0] tidx;
   logic mem_we;
   logic second_tick;
   logic [7:0] rd_byte;

   always_comb begin
      selected = !sel1_n_s && sel2_s && !blocked_reg;
      read_mode = selected && wr_n_s; // R1
      write_mode = selected && !wr_n_s; // R5
      sel_rise = selected && !sel_d_reg;
      write_start = write_mode && (wr_n_d_reg || sel_rise); // R6
      in_clock = (addr_s >= ADDR_CONTROL); // R24
      tidx = 3'(addr_s - ADDR_SECONDS);
      halt = control_reg[CTL_WRITE_BIT] || control_reg[CTL_READ_BIT]; // R15 R19
      mem_we = (state_reg == BBC_WRITE) && write_mode && !in_clock; // R6
      second_tick = (tick_reg == CNT_LAST);
   end

   // Main RAM; only the addressed byte is touched by a write
   always_ff @(posedge clk) begin
      if (ce && mem_we) begin
         mem[addr_s] <= din_s; // R2 R12
      end
   end

   // Read data selection
   always_comb begin
      if (addr_s == ADDR_CONTROL) begin
         rd_byte = control_reg;
      end else if (in_clock) begin
         rd_byte = tbyte_reg[tidx];
      end else begin
         rd_byte = mem[addr_s];
      end
   end

   // BCD carry chain for the running counters
   logic [7:0] inc_val [NUM_TIME];
   logic carry [NUM_TIME];
   logic [7:0] min_tab [NUM_TIME];
   logic [7:0] max_tab [NUM_TIME];
   assign min_tab = '{BCD_ZERO, BCD_ZERO, BCD_ZERO, BCD_ONE, BCD_ONE, BCD_ONE, BCD_ZERO};
   assign max_tab = '{BCD_MINSEC_MAX, BCD_MINSEC_MAX, BCD_HOUR_MAX, BCD_DAY_MAX,
                      BCD_DATE_MAX, BCD_MONTH_MAX, BCD_YEAR_MAX};
   genvar gi;
   generate
      for (gi = 0; gi < NUM_TIME; gi++) begin : g_digit
         // Day and date both advance on the hour carry
         logic inc_in;
         if (gi == 0) begin : g_first
            assign inc_in = second_tick;
         end else if (gi == 4) begin : g_date
            assign inc_in = carry[2];
         end else begin : g_rest
            assign inc_in = carry[gi-1];
         end
         bbc_bcd_digit u_digit (
            .value(cnt_reg[gi]),
            .min_val(min_tab[gi]),
            .max_val(max_tab[gi]),
            .inc(inc_in),
            .next_val(inc_val[gi]),
            .carry(carry[gi])
         );
      end
   endgenerate

   // Bus sequencer and control
   always_comb begin
      state_next = state_reg;
      control_next = control_reg;
      dout_next = dout_reg;
      oe_next = 1'b0;
      last_addr_next = last_addr_reg;
      float_next = float_reg;
      blocked_next = blocked_reg;
      wr_n_d_next = wr_n_s;
      sel_d_next = selected;
      // Upper trip needed before writes return
      if (!pf_low_s) begin
         blocked_next = 1'b1; // R11
      end else if (pf_high_s) begin
         blocked_next = 1'b0; // R13
      end
      case (state_reg)
         BBC_IDLE: begin
            if (blocked_reg) begin
               state_next = BBC_FAIL;
            end else if (write_mode) begin
               state_next = write_start ? BBC_WRITE : BBC_IDLE;
               float_next = sel_rise; // R10
            end else if (read_mode) begin
               state_next = BBC_READ;
            end
         end
         BBC_READ: begin
            if (!read_mode) begin
               state_next = write_mode ? BBC_WRITE : BBC_IDLE; // R9
               float_next = 1'b0;
            end else begin
               // Data drives only with gate low
               oe_next = !gate_n_s && !float_reg; // R3
               if (addr_s != last_addr_reg) begin
                  dout_next = {DATA_W{1'b0}}; // R4
               end else begin
                  dout_next = rd_byte; // R1
               end
            end
         end
         BBC_WRITE: begin
            // Strobe or select inactive ends the write
            if (!write_mode) begin
               state_next = BBC_IDLE; // R6
               float_next = 1'b0;
            end else if (addr_s == ADDR_CONTROL) begin
               control_next = din_s;
            end
         end
         BBC_FAIL: begin
            if (!blocked_reg) begin
               state_next = BBC_IDLE;
            end
         end
         default: state_next = BBC_IDLE;
      endcase
      last_addr_next = addr_s;
   end

   // Timekeeping: counters free-run, bytes copy when not halted
   always_comb begin
      tick_next = second_tick ? CNT_ZERO : CNT_W'(tick_reg + 1'b1);
      pend_next = pend_reg;
      for (int i = 0; i < NUM_TIME; i++) begin
         cnt_next[i] = inc_val[i]; // R14
         tbyte_next[i] = tbyte_reg[i];
      end
      // Update in one step, and only between halts
      if (!halt && (second_tick || pend_reg)) begin
         for (int i = 0; i < NUM_TIME; i++) begin
            tbyte_next[i] = inc_val[i]; // R17 R25
         end
         pend_next = 1'b0; // R18
      end else if (halt && second_tick) begin
         // A tick missed while halted refreshes at once on release
         pend_next = 1'b1; // R16
      end
      // Host writes into the time bytes
      if (state_reg == BBC_WRITE && write_mode && in_clock && addr_s != ADDR_CONTROL) begin
         tbyte_next[tidx] = din_s;
      end
      // Write-halt falling: counters take the loaded bytes
      if (control_reg[CTL_WRITE_BIT] && !control_next[CTL_WRITE_BIT]) begin
         for (int i = 0; i < NUM_TIME; i++) begin
            cnt_next[i] = tbyte_reg[i]; // R20
         end
         tick_next = CNT_ZERO;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= BBC_IDLE;
         control_reg <= CONTROL_RESET;
         dout_reg <= '0;
         oe_reg <= 1'b0;
         last_addr_reg <= '0;
         float_reg <= 1'b0;
         blocked_reg <= 1'b1;
         wr_n_d_reg <= 1'b1;
         sel_d_reg <= 1'b0;
         tick_reg <= CNT_ZERO;
         pend_reg <= 1'b0;
         for (int i = 0; i < NUM_TIME; i++) begin
            cnt_reg[i] <= min_tab_rst(i);
            tbyte_reg[i] <= min_tab_rst(i);
         end
      end else if (ce) begin
         state_reg <= state_next;
         control_reg <= control_next;
         dout_reg <= dout_next;
         oe_reg <= oe_next;
         last_addr_reg <= last_addr_next;
         float_reg <= float_next;
         blocked_reg <= blocked_next;
         wr_n_d_reg <= wr_n_d_next;
         sel_d_reg <= sel_d_next;
         tick_reg <= tick_next;
         pend_reg <= pend_next;
         cnt_reg <= cnt_next;
         tbyte_reg <= tbyte_next;
      end
   end

   // Constant reset value per time byte
   function automatic logic [7:0] min_tab_rst(input int idx);
      min_tab_rst = (idx >= 3 && idx <= 5) ? BCD_ONE : BCD_ZERO;
   endfunction : min_tab_rst

   assign data_out = dout_reg;
   assign data_oe = oe_reg;

   // Checks
   chk_oe_needs_read: assert property (@(posedge clk) disable iff (!nrst)
      oe_reg |-> $past(state_reg == BBC_READ && !gate_n_s)) // R3
      else $error("data driven outside gated read");
   chk_fail_floats: assert property (@(posedge clk) disable iff (!nrst)
      $past(blocked_reg) && $past(ce) |-> !oe_reg) // R11
      else $error("outputs driven during power fail");
   chk_halt_freezes: assert property (@(posedge clk) disable iff (!nrst)
      ce && halt && !(state_reg == BBC_WRITE) |=> $stable(tbyte_reg[0])) // R16
      else $error("time byte changed while halted");
   chk_wr_releases: assert property (@(posedge clk) disable iff (!nrst)
      ce && state_reg == BBC_READ && write_mode |=> !oe_reg) // R9
      else $error("outputs not released on write strobe");
   chk_block_write: assert property (@(posedge clk) disable iff (!nrst)
      blocked_reg |-> !mem_we) // R13
      else $error("write while protected");
   chk_tick_update: assert property (@(posedge clk) disable iff (!nrst)
      ce && second_tick && !halt && !(state_reg == BBC_WRITE) |=>
      tbyte_reg[0] == cnt_reg[0]) // R25
      else $error("time bytes not refreshed");
   chk_counter_runs: assert property (@(posedge clk) disable iff (!nrst)
      ce && second_tick && !control_reg[CTL_WRITE_BIT] |=> cnt_reg[0] != $past(cnt_reg[0])) // R14
      else $error("counters stopped");
   chk_float_cycle: assert property (@(posedge clk) disable iff (!nrst)
      float_reg |-> !oe_reg) // R10
      else $error("outputs driven in floated cycle");
   cov_read: cover property (@(posedge clk) disable iff (!nrst) oe_reg);
   cov_write: cover property (@(posedge clk) disable iff (!nrst) mem_we);
   cov_halt: cover property (@(posedge clk) disable iff (!nrst) halt && second_tick);
   cov_fail: cover property (@(posedge clk) disable iff (!nrst) state_reg == BBC_FAIL);
endmodule : bbc_top
`default_nettype wire

// File: inc/bbc_pkg.sv
package bbc_pkg;
   // Memory geometry
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int DEPTH = 8192;
   // Timekeeping byte addresses
   localparam logic [12:0] ADDR_CONTROL = 13'h1ff8;
   localparam logic [12:0] ADDR_SECONDS = 13'h1ff9;
   localparam logic [12:0] ADDR_MINUTES = 13'h1ffa;
   localparam logic [12:0] ADDR_HOURS = 13'h1ffb;
   localparam logic [12:0] ADDR_DAY = 13'h1ffc;
   localparam logic [12:0] ADDR_DATE = 13'h1ffd;
   localparam logic [12:0] ADDR_MONTH = 13'h1ffe;
   localparam logic [12:0] ADDR_YEAR = 13'h1fff;
   localparam int NUM_TIME = 7;
   // Control byte fields
   localparam int CTL_WRITE_BIT = 7;
   localparam int CTL_READ_BIT = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // Time counter reset values and wrap limits
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] BCD_DAY_MAX = 8'h07;
   localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
   localparam logic [7:0] BCD_MINSEC_MAX = 8'h59;
   localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
   localparam logic [7:0] BCD_YEAR_MAX = 8'h99;
   localparam logic [7:0] BCD_DATE_MAX = 8'h31;
   // Timing
   localparam int CLK_MHZ = 250;
   localparam int SECOND_S = 1;
   localparam int SECOND_CYCLES = SECOND_S * CLK_MHZ * 1000000;
   // Bus sequencer states
   typedef enum logic [3:0] {
      BBC_IDLE = 4'b0001,
      BBC_READ = 4'b0010,
      BBC_WRITE = 4'b0100,
      BBC_FAIL = 4'b1000
   } bbc_state_t;
endpackage : bbc_pkg

// File: src/bbc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bbc_sync
   import bbc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   // Two stages; first stage feeds only the second
   always_comb begin
      meta_next = ce ? async_in : meta_reg;
      sync_next = ce ? meta_reg : sync_reg;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule : bbc_sync
`default_nettype wire

// File: src/bbc_bcd_digit.sv
`timescale 1ns/1ps
`default_nettype none
module bbc_bcd_digit
   import bbc_pkg::*;
(
   // Current value and limits
   input wire logic [7:0] value,
   input wire logic [7:0] min_val,
   input wire logic [7:0] max_val,
   input wire logic inc,
   // Result
   output logic [7:0] next_val,
   output logic carry
);
   // BCD increment with wrap to the minimum
   always_comb begin
      next_val = value;
      carry = 1'b0;
      if (inc) begin
         if (value >= max_val) begin
            next_val = min_val;
            carry = 1'b1;
         end else if (value[3:0] == 4'h9) begin
            next_val = {value[7:4] + 4'h1, 4'h0};
         end else begin
            next_val = {value[7:4], value[3:0] + 4'h1};
         end
      end
   end
endmodule : bbc_bcd_digit
`default_nettype wire

// File: tb/bbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bbc_host_model
   import bbc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Bus pins toward the device
   output logic [ADDR_W-1:0] byte_address,
   output logic [DATA_W-1:0] data_in,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_oe,
   output logic select_one_n,
   output logic select_two,
   output logic output_gate_n,
   output logic write_strobe_n
);
   logic [DATA_W-1:0] drv = 8'h00;
   logic [DATA_W-1:0] last_bus = 8'h00;
   logic host_oe = 1'b0;

   // Resolved wire; a floating bus toggles so stale data never passes for a read
   assign data_in = (data_oe && host_oe) ? 8'hxx : data_oe ? data_out : host_oe ? drv : ~last_bus;
   always @(posedge clk) begin
      last_bus <= data_in;
   end

   // Pins idle from time zero
   initial begin
      byte_address = 13'h0000;
      select_one_n = 1'b1;
      select_two = 1'b0;
      output_gate_n = 1'b1;
      write_strobe_n = 1'b1;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // Sets every pin at once, just after an edge
   task automatic pins(input logic [12:0] a, input logic s1_n, s2, g_n, wr_n, hoe,
                       input logic [7:0] d);
      byte_address = a;
      select_one_n = s1_n;
      select_two = s2;
      output_gate_n = g_n;
      write_strobe_n = wr_n;
      host_oe = hoe;
      drv = d;
   endtask : pins

   // Byte write; mode 1 lets the strobe lead and select two end it first
   task automatic write_byte(input logic [12:0] a, input logic [7:0] d, input logic gate_n,
                             input logic mode, output logic saw_oe);
      saw_oe = 1'b0;
      pins(a, 1'b1, 1'b0, gate_n, mode ? 1'b0 : 1'b1, 1'b1, d);
      cyc(mode ? 2 : 1);
      pins(a, 1'b0, 1'b1, gate_n, 1'b0, 1'b1, d);
      repeat (6) begin
         cyc(1);
         saw_oe |= (data_oe !== 1'b0);
      end
      if (mode) begin
         select_two = 1'b0;
         cyc(2);
      end
      pins(a, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, d);
      cyc(3);
      host_oe = 1'b0;
      cyc(1);
   endtask : write_byte

   // Read with given select and gate levels; hold leaves the access open
   task automatic read_byte(input logic [12:0] a, input logic s1_n, s2, g_n, hold,
                            output logic [7:0] d, output logic drove);
      drove = 1'b0;
      d = 8'h00;
      pins(a, s1_n, s2, g_n, 1'b1, 1'b0, 8'h00);
      for (int i = 0; i < 10 && !drove; i++) begin
         cyc(1);
         drove = (data_oe === 1'b1);
      end
      if (drove) begin
         cyc(2);
         d = data_in;
      end
      if (!hold) begin
         pins(a, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
         cyc(6);
      end
   endtask : read_byte
endmodule : bbc_host_model
`default_nettype wire

// File: tb/battery_backed_sram_clock_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
module battery_backed_sram_clock_access_tb
   import bbc_pkg::*;
;
   localparam int SEC = 200;
   logic clk = 1'b0;
   logic nrst;
   logic ce;
   logic sup_lo;
   logic sup_hi;
   logic [12:0] addr;
   logic [7:0] din, dout;
   logic oe, s1_n, s2, g_n, wr_n;
   int err_total = 0;
   int comparisons = 0;

   // Clock
   always #2 clk = ~clk;

   bbc_top #(.SECOND_COUNT(SEC)) u_dut (.clk(clk), .nrst(nrst), .ce(ce), .byte_address(addr),
      .data_in(din), .data_out(dout), .data_oe(oe), .select_one_n(s1_n), .select_two(s2),
      .output_gate_n(g_n), .write_strobe_n(wr_n), .supply_above_low(sup_lo),
      .supply_above_high(sup_hi));
   bbc_host_model u_host (.clk(clk), .byte_address(addr), .data_in(din), .data_out(dout),
      .data_oe(oe), .select_one_n(s1_n), .select_two(s2), .output_gate_n(g_n),
      .write_strobe_n(wr_n));

   task automatic check(input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      if (err_total == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run

   // Plain write with the gate high; outputs must stay off
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic s;
      u_host.write_byte(a, d, 1'b1, 1'b0, s);
      check({7'h00, s}, 8'h00);
   endtask : wr

   // Selected, gated read; no answer ends the run
   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic dr;
      u_host.read_byte(a, 1'b0, 1'b1, 1'b0, 1'b0, d, dr);
      if (dr !== 1'b1) begin
         err_total++;
         complete_run();
      end else begin
         check(d, exp);
      end
   endtask : rd

   // Polls a time byte until it moves, within about one second
   task automatic poll(input logic [7:0] old, output logic [7:0] d);
      logic dr;
      d = old;
      for (int i = 0; i < 20 && d === old; i++) begin
         u_host.read_byte(ADDR_SECONDS, 1'b0, 1'b1, 1'b0, 1'b0, d, dr);
      end
      if (d === old) begin
         err_total++;
         complete_run();
      end
   endtask : poll

   // Array corners and both write styles
   task automatic t_ram;
      logic s;
      rd(ADDR_CONTROL, CONTROL_RESET);
      wr(13'h0000, 8'ha5);
      wr(13'h1ff7, 8'h3c);
      wr(13'h1000, 8'h5a);
      u_host.write_byte(13'h0001, 8'hc3, 1'b1, 1'b1, s);
      rd(13'h0000, 8'ha5);
      rd(13'h1ff7, 8'h3c);
      rd(13'h1000, 8'h5a);
      rd(13'h0001, 8'hc3);
   endtask : t_ram

   // Each missing select or gate keeps the lines floating
   task automatic t_gate;
      logic [2:0] combo [3] = '{3'b110, 3'b000, 3'b011};
      logic [7:0] d;
      logic dr;
      foreach (combo[i]) begin
         u_host.read_byte(13'h0000, combo[i][2], combo[i][1], combo[i][0], 1'b0, d, dr);
         check({7'h00, dr}, 8'h00);
      end
   endtask : t_gate

   // Strobe falls during a driven read, then writes
   task automatic t_strobe;
      logic [7:0] d;
      logic dr;
      u_host.read_byte(13'h1000, 1'b0, 1'b1, 1'b0, 1'b1, d, dr);
      check({7'h00, dr}, 8'h01);
      u_host.pins(13'h1000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h96);
      u_host.cyc(6);
      check({7'h00, oe}, 8'h00);
      u_host.pins(13'h1000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h96);
      u_host.cyc(6);
      u_host.pins(13'h1000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h96);
      u_host.cyc(3);
      u_host.pins(13'h1000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h96);
      u_host.cyc(1);
      rd(13'h1000, 8'h96);
   endtask : t_strobe

   // Select and strobe fall together with the gate low
   task automatic t_simul;
      logic s;
      u_host.write_byte(13'h0002, 8'h69, 1'b0, 1'b0, s);
      check({7'h00, s}, 8'h00);
      rd(13'h0002, 8'h69);
   endtask : t_simul

   // Supply drop, partial return, full return
   task automatic t_power;
      logic [7:0] d;
      logic dr, s;
      wr(13'h0003, 8'h11);
      sup_lo = 1'b0;
      sup_hi = 1'b0;
      u_host.cyc(4);
      u_host.read_byte(13'h0003, 1'b0, 1'b1, 1'b0, 1'b0, d, dr);
      check({7'h00, dr}, 8'h00);
      u_host.write_byte(13'h0003, 8'hee, 1'b1, 1'b0, s);
      sup_lo = 1'b1;
      u_host.cyc(4);
      u_host.write_byte(13'h0003, 8'hdd, 1'b1, 1'b0, s);
      sup_hi = 1'b1;
      u_host.cyc(4);
      rd(13'h0003, 8'h11);
      rd(13'h0000, 8'ha5);
      wr(13'h0003, 8'h22);
      rd(13'h0003, 8'h22);
   endtask : t_power

   // Address moves mid-read, then a low clock enable freezes the read
   task automatic t_hold;
      logic [7:0] d;
      logic dr;
      u_host.read_byte(13'h0000, 1'b0, 1'b1, 1'b0, 1'b1, d, dr);
      check(d, 8'ha5);
      u_host.pins(13'h1000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
      u_host.cyc(2);
      check(dout, 8'ha5);
      u_host.cyc(1);
      check(dout, 8'h00);
      u_host.cyc(1);
      check(dout, 8'h96);
      ce = 1'b0;
      u_host.pins(13'h0000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
      u_host.cyc(6);
      check(dout, 8'h96);
      check({7'h00, oe}, 8'h01);
      ce = 1'b1;
      u_host.cyc(4);
      check(dout, 8'ha5);
      u_host.pins(13'h0000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
      u_host.cyc(6);
   endtask : t_hold

   // Mid-run reset clears control and outputs, keeps the array
   task automatic t_reset;
      wr(ADDR_CONTROL, 8'h40);
      nrst = 1'b0;
      u_host.cyc(1);
      check({7'h00, oe}, 8'h00);
      check(dout, 8'h00);
      u_host.cyc(1);
      nrst = 1'b1;
      u_host.cyc(5);
      rd(ADDR_CONTROL, CONTROL_RESET);
      rd(13'h0000, 8'ha5);
   endtask : t_reset

   // Write halt load, then read halt freeze and resume
   task automatic t_clock;
      logic [7:0] d, s1;
      logic dr;
      wr(ADDR_CONTROL, 8'h80);
      rd(ADDR_CONTROL, 8'h80);
      wr(ADDR_SECONDS, 8'h30);
      u_host.cyc(3 * SEC);
      rd(ADDR_SECONDS, 8'h30);
      wr(ADDR_CONTROL, 8'h00);
      poll(8'h30, d);
      check(d, 8'h31);
      wr(ADDR_CONTROL, 8'h40);
      u_host.read_byte(ADDR_SECONDS, 1'b0, 1'b1, 1'b0, 1'b0, s1, dr);
      u_host.cyc(3 * SEC);
      rd(ADDR_SECONDS, s1);
      wr(ADDR_CONTROL, 8'h00);
      poll(s1, d);
      check({7'h00, d >= s1 + 8'h03}, 8'h01);
   endtask : t_clock

   // Reset for two cycles, then the scenarios
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      sup_lo = 1'b1;
      sup_hi = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      nrst = 1'b1;
      u_host.cyc(5);
      t_ram();
      t_gate();
      t_strobe();
      t_simul();
      t_power();
      t_hold();
      t_clock();
      t_reset();
      complete_run();
   end
endmodule : battery_backed_sram_clock_access_tb
`default_nettype wire
